// *** src/port_io_pkg.sv ***
// Shared constants for the port I/O crossbar block.
// Assumes pin index 0..7 is port 0, 8..15 port 1, 16..17 port 2.
package port_io_pkg;
	// ------------------------------------------------------------
	// Pin and port geometry
	// ------------------------------------------------------------
	localparam int NUM_PINS  = 18;
	localparam int XBAR_PINS = 16;
	localparam int NUM_PORTS = 3;
	localparam int PORT_W    = 8;
	localparam int UART_TX_PIN = 4;
	localparam int UART_RX_PIN = 5;
	// ------------------------------------------------------------
	// Routed signal indices, in priority order
	// ------------------------------------------------------------
	localparam int NUM_SIG  = 18;
	localparam int SIG_W    = 5;
	localparam int SIG_SCK  = 0;
	localparam int SIG_MISO = 1;
	localparam int SIG_MOSI = 2;
	localparam int SIG_NSS  = 3;
	localparam int SIG_SDA  = 4;
	localparam int SIG_SCL  = 5;
	localparam int SIG_CP0  = 6;
	localparam int SIG_CP0A = 7;
	localparam int SIG_CP1  = 8;
	localparam int SIG_CP1A = 9;
	localparam int SIG_SYSCLK = 10;
	localparam int SIG_CEX0 = 11;
	localparam int SIG_CEX1 = 12;
	localparam int SIG_CEX2 = 13;
	localparam int SIG_ECI  = 14;
	localparam int SIG_T0   = 15;
	localparam int SIG_T1   = 16;
	localparam int SIG_T2   = 17;
	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [17:0] LATCH_RST = 18'h3ffff;
	localparam logic [2:0]  DRIVE_RST = 3'h7;
	localparam logic [1:0]  SS_THREE_WIRE = 2'h0;
	localparam logic [1:0]  PORT2 = 2'h2;

	// Byte view of one port out of an 18-pin vector; absent bits read 0
	function automatic logic [7:0] port_byte(input logic [17:0] v, input logic [1:0] n);
		case (n)
			2'h0:    port_byte = v[7:0];
			2'h1:    port_byte = v[15:8];
			2'h2:    port_byte = {6'h00, v[17:16]};
			default: port_byte = 8'h00;
		endcase
	endfunction
endpackage

// *** src/priority_crossbar_port_io.sv ***
// Priority crossbar decoder and port pin cells for 18 port pins.
// Assumes all inputs are synchronous to clk; pad wire resolution
// from pad_out/pad_oe is done outside this module.
`timescale 1ns/1ps
`default_nettype none
module priority_crossbar_port_io
	import port_io_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Pin configuration
	input  wire logic [NUM_PINS-1:0]  input_mode_select,
	input  wire logic [NUM_PINS-1:0]  output_mode_select,
	input  wire logic [XBAR_PINS-1:0] pin_skip_mask,
	input  wire logic                 crossbar_enable,
	input  wire logic                 pullup_disable,
	// Routing selection
	input  wire logic                 serial_en,
	input  wire logic                 spi_en,
	input  wire logic [1:0]           slave_select_mode,
	input  wire logic                 two_wire_en,
	input  wire logic                 two_wire_swap,
	input  wire logic                 cmp0_en,
	input  wire logic                 cmp0_async_en,
	input  wire logic                 cmp1_en,
	input  wire logic                 cmp1_async_en,
	input  wire logic                 sysclk_out_en,
	input  wire logic [1:0]           counter_channels,
	input  wire logic                 ext_count_en,
	input  wire logic [2:0]           timer_in_en,
	// Peripheral side
	input  wire logic                 serial_tx,
	output logic                      serial_rx,
	input  wire logic [NUM_SIG-1:0]   periph_out,
	input  wire logic [NUM_SIG-1:0]   periph_drive,
	output logic [NUM_SIG-1:0]        periph_in,
	// Port latch access
	input  wire logic                 port_wr,
	input  wire logic [1:0]           port_sel,
	input  wire logic [PORT_W-1:0]    port_wdata,
	input  wire logic                 bit_wr,
	input  wire logic [4:0]           bit_sel,
	input  wire logic                 bit_val,
	input  wire logic                 port_rd,
	input  wire logic [1:0]           port_rd_sel,
	input  wire logic                 port_rd_rmw,
	output logic [PORT_W-1:0]         port_rdata,
	output logic                      port_rd_valid,
	// Drive strength
	input  wire logic                 drive_wr,
	input  wire logic [NUM_PORTS-1:0] drive_wdata,
	output logic [NUM_PORTS-1:0]      drive_high,
	// Port match
	input  wire logic [XBAR_PINS-1:0] expected_level_pattern,
	input  wire logic [XBAR_PINS-1:0] compare_select_mask,
	output logic                      mismatch_event,
	// Pads
	input  wire logic [NUM_PINS-1:0]  pad_in,
	output logic [NUM_PINS-1:0]       pad_out,
	output logic [NUM_PINS-1:0]       pad_oe,
	output logic [NUM_PINS-1:0]       pad_pullup,
	output logic [NUM_PINS-1:0]       pad_rx_en
);
	// ------------------------------------------------------------
	// Signal enables
	// ------------------------------------------------------------
	logic [NUM_SIG-1:0] sig_en;
	logic [NUM_PINS-1:0] pad_dig;

	// Digital receive level; analog pins read as 0
	assign pad_dig = pad_in & input_mode_select;

	// One enable per routable signal, in priority order
	always_comb begin
		sig_en = '0;
		sig_en[SIG_SCK]  = spi_en;
		sig_en[SIG_MISO] = spi_en;
		sig_en[SIG_MOSI] = spi_en;
		sig_en[SIG_NSS]  = spi_en && (slave_select_mode != SS_THREE_WIRE);
		sig_en[SIG_SDA]  = two_wire_en;
		sig_en[SIG_SCL]  = two_wire_en;
		sig_en[SIG_CP0]  = cmp0_en;
		sig_en[SIG_CP0A] = cmp0_async_en;
		sig_en[SIG_CP1]  = cmp1_en;
		sig_en[SIG_CP1A] = cmp1_async_en;
		sig_en[SIG_SYSCLK] = sysclk_out_en;
		sig_en[SIG_CEX0] = counter_channels != 2'h0;
		sig_en[SIG_CEX1] = counter_channels[1];
		sig_en[SIG_CEX2] = counter_channels == 2'h3;
		sig_en[SIG_ECI]  = ext_count_en;
		sig_en[SIG_T0]   = timer_in_en[0];
		sig_en[SIG_T1]   = timer_in_en[1];
		sig_en[SIG_T2]   = timer_in_en[2];
	end

	// ------------------------------------------------------------
	// Priority decoder
	// ------------------------------------------------------------
	logic [NUM_PINS-1:0]  occ;
	logic [NUM_PINS-1:0]  route_hit;
	logic [SIG_W-1:0]     route_sel [NUM_PINS];
	logic [SIG_W-1:0]     eff_sig;
	logic                 found;

	// Walk signals by priority; each takes the lowest unoccupied pin.
	// Fully combinational: a config change reroutes in the next cycle.
	// A signal that finds no free pin is dropped without any warning,
	// so firmware has to budget pins against the enables it sets.
	always_comb begin
		occ = {2'h3, pin_skip_mask}; // port 2 pins never route
		route_hit = '0;
		eff_sig = '0;
		found = 1'b0;
		for (int p = 0; p < NUM_PINS; p++) begin
			route_sel[p] = '0;
		end
		if (serial_en) begin
			occ[UART_TX_PIN] = 1'b1;
			occ[UART_RX_PIN] = 1'b1;
		end
		for (int s = 0; s < NUM_SIG; s++) begin
			eff_sig = SIG_W'(s);
			if (two_wire_swap && s == SIG_SDA) begin
				eff_sig = SIG_W'(SIG_SCL); // swapped order
			end
			if (two_wire_swap && s == SIG_SCL) begin
				eff_sig = SIG_W'(SIG_SDA);
			end
			found = 1'b0;
			if (sig_en[eff_sig]) begin
				for (int p = 0; p < XBAR_PINS; p++) begin
					if (!found && !occ[p]) begin
						occ[p] = 1'b1;
						route_hit[p] = 1'b1;
						route_sel[p] = eff_sig;
						found = 1'b1;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pin cell control
	// ------------------------------------------------------------
	logic [NUM_PINS-1:0] latch_r;
	logic [NUM_PINS-1:0] out_nxt;
	logic [NUM_PINS-1:0] oe_nxt;
	logic [NUM_PINS-1:0] pu_nxt;
	logic [NUM_SIG-1:0]  pin_in_nxt;
	logic                val;
	logic                drv;
	logic                pp;

	// Output value, driver enables and pull-up per pin
	always_comb begin
		out_nxt = '0;
		oe_nxt = '0;
		pu_nxt = '0;
		pin_in_nxt = '0;
		val = 1'b1;
		drv = 1'b0;
		pp = 1'b0;
		for (int p = 0; p < NUM_PINS; p++) begin
			val = latch_r[p]; // unclaimed pins are GPIO
			drv = 1'b1;
			pp = output_mode_select[p];
			if (serial_en && p == UART_TX_PIN) begin
				val = serial_tx;
			end else if (serial_en && p == UART_RX_PIN) begin
				val = 1'b1; // receive pin stays undriven
				drv = 1'b0;
			end else if (route_hit[p]) begin
				val = periph_out[route_sel[p]];
				drv = periph_drive[route_sel[p]];
				pin_in_nxt[route_sel[p]] = pad_dig[p];
				if (route_sel[p] == SIG_W'(SIG_SDA) || route_sel[p] == SIG_W'(SIG_SCL)) begin
					pp = 1'b0; // Two-wire lines are always open-drain
				end
			end
			// Driver only when crossbar on and pin digital
			oe_nxt[p] = crossbar_enable && input_mode_select[p] && drv && (pp || !val);
			out_nxt[p] = val && pp;
			// Pull-up only while undriven and digital
			pu_nxt[p] = input_mode_select[p] && !pullup_disable && !oe_nxt[p];
		end
	end

	// Registered pad controls; reset leaves every pin floating with pull-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out <= '0;
			pad_oe <= '0;
			pad_pullup <= '1;
			pad_rx_en <= '1;
		end else begin
			pad_out <= out_nxt;
			pad_oe <= oe_nxt;
			pad_pullup <= pu_nxt;
			pad_rx_en <= input_mode_select;
		end
	end

	// Pad levels returned to the peripherals
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_in <= '0;
			serial_rx <= 1'b1;
		end else begin
			periph_in <= pin_in_nxt;
			serial_rx <= serial_en ? pad_dig[UART_RX_PIN] : 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Port latch and read path
	// ------------------------------------------------------------
	// Byte write and bit write; a bit write lands on top of a byte write.
	// Indices past the last pin are ignored so they never alias a real pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r <= LATCH_RST;
		end else begin
			if (port_wr) begin
				for (int b = 0; b < PORT_W; b++) begin
					if (int'(port_sel) * PORT_W + b < NUM_PINS) begin
						latch_r[int'(port_sel) * PORT_W + b] <= port_wdata[b];
					end
				end
			end
			if (bit_wr && int'(bit_sel) < NUM_PINS) begin
				latch_r[bit_sel] <= bit_val;
			end
		end
	end

	// Normal reads see the pads, read-modify-write sees the latch.
	// Analog pins read 0 either way.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_rdata <= '0;
			port_rd_valid <= 1'b0;
		end else begin
			port_rd_valid <= port_rd;
			if (port_rd) begin
				if (port_rd_rmw) begin
					port_rdata <= port_byte(latch_r & input_mode_select, port_rd_sel);
				end else begin
					port_rdata <= port_byte(pad_dig, port_rd_sel);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Drive strength and port match
	// ------------------------------------------------------------
	// One bit per port, high drive after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_high <= DRIVE_RST;
		end else if (drive_wr) begin
			drive_high <= drive_wdata;
		end
	end

	// Compares pad levels directly, so routing has no effect.
	// Level output: stays high as long as the mismatch lasts.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mismatch_event <= 1'b0;
		end else begin
			mismatch_event <= (pad_dig[XBAR_PINS-1:0] & compare_select_mask)
				!= (expected_level_pattern & compare_select_mask);
		end
	end
endmodule // priority_crossbar_port_io
`default_nettype wire

// *** bench/port_io_chk.sv ***
// Checker for pad, read, drive and match timing of the port block.
// Bound to the top module; inputs change away from the rising edge.
`timescale 1ns/1ps
`default_nettype none
module port_io_chk
	import port_io_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration
	input wire logic [NUM_PINS-1:0] input_mode_select,
	input wire logic [NUM_PINS-1:0] output_mode_select,
	input wire logic crossbar_enable,
	input wire logic pullup_disable,
	// Reads and drive
	input wire logic port_rd,
	input wire logic [1:0] port_rd_sel,
	input wire logic port_rd_rmw,
	input wire logic [PORT_W-1:0] port_rdata,
	input wire logic port_rd_valid,
	input wire logic drive_wr,
	input wire logic [NUM_PORTS-1:0] drive_wdata,
	input wire logic [NUM_PORTS-1:0] drive_high,
	// Match and pads
	input wire logic [XBAR_PINS-1:0] expected_level_pattern,
	input wire logic [XBAR_PINS-1:0] compare_select_mask,
	input wire logic mismatch_event,
	input wire logic [NUM_PINS-1:0] pad_in,
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe,
	input wire logic [NUM_PINS-1:0] pad_pullup,
	input wire logic [NUM_PINS-1:0] pad_rx_en
);
	// ----
	// Properties; the first edge after reset still sees reset inputs
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_xbar_off_quiet: assert property ($past(rst_n) && !$past(crossbar_enable) |-> pad_oe == '0)
		else $error("pad driven with crossbar off");
	a_analog_cell_off: assert property ($past(rst_n) |-> ((pad_oe | pad_pullup) & ~$past(input_mode_select)) == '0
		&& pad_rx_en == $past(input_mode_select))
		else $error("analog pin cell active");
	a_pullup_rule: assert property ($past(rst_n) |->
		pad_pullup == ($past(input_mode_select) & ~pad_oe & {NUM_PINS{!$past(pullup_disable)}}))
		else $error("pull-up state wrong");
	a_open_drain_low: assert property ((pad_oe & pad_out & ~$past(output_mode_select)) == '0)
		else $error("open-drain pin driven high");
	a_read_valid_pulse: assert property ($past(rst_n) |-> port_rd_valid == $past(port_rd))
		else $error("read valid timing wrong");
	a_read_pad_level: assert property (port_rd && !port_rd_rmw && port_rd_sel == 2'h0 |=>
		port_rdata == ($past(pad_in[7:0]) & $past(input_mode_select[7:0])))
		else $error("pin read data wrong");
	a_drive_load: assert property (drive_wr |=> drive_high == $past(drive_wdata))
		else $error("drive strength not loaded");
	a_drive_hold: assert property ($past(rst_n) && !$past(drive_wr) |-> $stable(drive_high))
		else $error("drive strength changed");
	a_match_event: assert property ($past(rst_n) |-> mismatch_event ==
		((($past(pad_in[15:0]) & $past(input_mode_select[15:0])) & $past(compare_select_mask))
		!= ($past(expected_level_pattern) & $past(compare_select_mask))))
		else $error("mismatch event wrong");
	c_mismatch: cover property (mismatch_event);
	c_rmw_read: cover property (port_rd && port_rd_rmw);
	c_xbar_drive: cover property (crossbar_enable && pad_oe != '0);
endmodule // port_io_chk

bind priority_crossbar_port_io port_io_chk u_chk (.*);
`default_nettype wire

// *** bench/pad_circuit.sv ***
// Outside circuitry on the pads: other drivers, pull-ups, floating pins.
// Assumes pad_oe high means the block drives the pad.
`timescale 1ns/1ps
`default_nettype none
module pad_circuit
	import port_io_pkg::*;
(
	// Clock
	input wire logic clk,
	// Block side
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe,
	input wire logic [NUM_PINS-1:0] pad_pullup,
	// Outside drivers and resolved level
	input wire logic [NUM_PINS-1:0] ext_oe,
	input wire logic [NUM_PINS-1:0] ext_val,
	output logic [NUM_PINS-1:0] pad_level
);
	// ----
	// Wire resolution
	// ----
	logic [NUM_PINS-1:0] float_r = 18'h15555;
	// A floating pad wanders each cycle so a stale level never passes
	always @(posedge clk) begin
		float_r <= ~float_r;
	end
	// Block wins, then outside driver, then pull-up
	assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
		| (~pad_oe & ~ext_oe & (pad_pullup | float_r));
endmodule // pad_circuit
`default_nettype wire

// *** bench/priority_crossbar_port_io_tb_top.sv ***
// Self-checking bench for the port crossbar block.
// Assumes the pad model resolves every pad from both sides.
`timescale 1ns/1ps
`default_nettype none
module priority_crossbar_port_io_tb_top;
	import port_io_pkg::*;
	// ----
	// Signals, design and pads
	// ----
	logic clk, rst_n, crossbar_enable, pullup_disable, serial_en, spi_en, two_wire_en, two_wire_swap;
	logic cmp0_en, cmp0_async_en, cmp1_en, cmp1_async_en, sysclk_out_en, ext_count_en, serial_tx, serial_rx;
	logic port_wr, bit_wr, bit_val, port_rd, port_rd_rmw, port_rd_valid, drive_wr, mismatch_event;
	logic [1:0] slave_select_mode, counter_channels, port_sel, port_rd_sel;
	logic [2:0] timer_in_en, drive_wdata, drive_high;
	logic [4:0] bit_sel;
	logic [7:0] port_wdata, port_rdata;
	logic [15:0] pin_skip_mask, expected_level_pattern, compare_select_mask;
	logic [17:0] input_mode_select, output_mode_select, periph_out, periph_drive, periph_in, pad_in;
	logic [17:0] pad_out, pad_oe, pad_pullup, pad_rx_en, ext_oe, ext_val;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	priority_crossbar_port_io DUT (.*);
	pad_circuit u_pads (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
		.ext_oe(ext_oe), .ext_val(ext_val), .pad_level(pad_in));
	// Clock and hang guard; the run needs under a hundred cycles
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			conclude();
		end
	end
	// ----
	// Tasks
	// ----
	task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s: %h exp %h", $time, what, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		@(negedge clk) {port_wr, port_sel, port_wdata} = {1'b1, sel, d};
		@(negedge clk) port_wr = 1'b0;
	endtask
	task automatic rd(input logic [1:0] sel, input logic rmw, input logic [7:0] exp);
		@(negedge clk) {port_rd, port_rd_sel, port_rd_rmw} = {1'b1, sel, rmw};
		@(negedge clk) port_rd = 1'b0;
		check(port_rd_valid, 18'h1, "read valid");
		check(port_rdata, exp, "read data");
	endtask
	// Pad drivers settle one edge after a configuration change
	task automatic route(input logic [15:0] exp);
		repeat (3) @(negedge clk);
		check(pad_oe[15:0], exp, "routed pins");
	endtask
	// ----
	// Test sequence
	// ----
	initial begin
		{clk, rst_n, crossbar_enable, pullup_disable, serial_en, spi_en, two_wire_en, two_wire_swap} = '0;
		{cmp0_en, cmp0_async_en, cmp1_en, cmp1_async_en, sysclk_out_en, ext_count_en, serial_tx} = '0;
		{port_wr, bit_wr, bit_val, port_rd, port_rd_rmw, drive_wr, bit_sel, port_wdata} = '0;
		{slave_select_mode, counter_channels, port_sel, port_rd_sel, timer_in_en, drive_wdata} = '0;
		{pin_skip_mask, expected_level_pattern, compare_select_mask, periph_out, ext_oe, ext_val} = '0;
		{input_mode_select, output_mode_select, periph_drive} = {18'h3ffff, 18'h3ffff, 18'h3ffff};
		repeat (11) @(negedge clk);
		check(pad_oe, 18'h0, "oe in reset");
		check(pad_pullup, 18'h3ffff, "pull-up in reset");
		check(drive_high, 18'h7, "drive in reset");
		@(negedge clk) rst_n = 1'b1;
		// Push-pull zeros stay off the pads until the crossbar is on
		wr(2'h0, 8'h00);
		ext_oe[8] = 1'b1;
		route(16'h0);
		rd(2'h0, 1'b0, 8'hff);
		rd(2'h0, 1'b1, 8'h00);
		$display("test crossbar off done");
		crossbar_enable = 1'b1;
		output_mode_select = 18'h000ff;
		wr(2'h0, 8'ha5);
		wr(2'h1, 8'h0f);
		route(16'hf0ff);
		check(pad_out[7:0], 18'ha5, "push-pull value");
		check(pad_pullup[15:0], 18'h0f00, "pull-ups");
		rd(2'h1, 1'b0, 8'h0e);
		@(negedge clk) {bit_wr, bit_sel, bit_val} = {1'b1, 5'd9, 1'b0};
		@(negedge clk) bit_wr = 1'b0;
		rd(2'h1, 1'b1, 8'h0d);
		{pullup_disable, input_mode_select} = {1'b1, 18'h3ff0f};
		route(16'hf20f);
		check(pad_pullup, 18'h0, "pull-ups disabled");
		check(pad_rx_en[7:0], 18'h0f, "receivers");
		rd(2'h0, 1'b1, 8'h05);
		$display("test gpio modes done");
		{pullup_disable, input_mode_select, output_mode_select, ext_oe} = {1'b0, 18'h3ffff, 36'h0};
		wr(2'h0, 8'hff);
		wr(2'h1, 8'hff);
		// Open-drain everywhere: only routed signals at 0 pull a pad
		{two_wire_en, periph_out[SIG_SDA]} = 2'h3;
		route(16'h0002);
		two_wire_swap = 1'b1;
		route(16'h0001);
		{two_wire_en, periph_out, serial_en, spi_en, pin_skip_mask} = {19'h0, 2'h3, 16'h0008};
		ext_oe[5] = 1'b1;
		route(16'h0017);
		check(serial_rx, 18'h0, "serial receive");
		slave_select_mode = 2'h1;
		route(16'h0057);
		{two_wire_en, cmp0_en, cmp0_async_en, cmp1_en, cmp1_async_en, sysclk_out_en} = '1;
		{counter_channels, ext_count_en, timer_in_en, periph_out[SIG_SYSCLK]} = '1;
		route(16'hdfd7);
		check(periph_in, 18'h00400, "peripheral inputs");
		crossbar_enable = 1'b0;
		route(16'h0);
		$display("test routing done");
		{ext_oe, expected_level_pattern, compare_select_mask} = {18'h0, 16'hffff, 16'h00f0};
		repeat (3) @(negedge clk);
		check(mismatch_event, 18'h0, "no mismatch");
		ext_oe[4] = 1'b1;
		repeat (3) @(negedge clk);
		check(mismatch_event, 18'h1, "mismatch");
		compare_select_mask = 16'h0f0f;
		repeat (3) @(negedge clk);
		check(mismatch_event, 18'h0, "masked off");
		@(negedge clk) {drive_wr, drive_wdata} = 4'ha;
		@(negedge clk) drive_wr = 1'b0;
		check(drive_high, 18'h2, "drive strength");
		$display("test match and drive done");
		conclude();
	end
endmodule // priority_crossbar_port_io_tb_top
`default_nettype wire
